// ---- bfau_core.v ----
// Bit-field access unit: descriptor walk, field load/store/compare/sense, AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "bfau_map.vh"
module bfau_core (
  input  wire        clk_i,           // Processor clock
  input  wire        resetn_i,        // Async reset, active low
  input  wire [7:0]  s_axi_awaddr,    // Write address
  input  wire        s_axi_awvalid,   // Write address valid
  output wire        s_axi_awready,   // Write address ready
  input  wire [31:0] s_axi_wdata,     // Write data
  input  wire [3:0]  s_axi_wstrb,     // Write byte strobes
  input  wire        s_axi_wvalid,    // Write data valid
  output wire        s_axi_wready,    // Write data ready
  output wire [1:0]  s_axi_bresp,     // Write response
  output wire        s_axi_bvalid,    // Write response valid
  input  wire        s_axi_bready,    // Write response ready
  input  wire [7:0]  s_axi_araddr,    // Read address
  input  wire        s_axi_arvalid,   // Read address valid
  output wire        s_axi_arready,   // Read address ready
  output wire [31:0] s_axi_rdata,     // Read data
  output wire [1:0]  s_axi_rresp,     // Read response
  output wire        s_axi_rvalid,    // Read data valid
  input  wire        s_axi_rready,    // Read data ready
  output wire        mem_req_o,       // Memory request, held until ready
  output wire        mem_we_o,        // Memory write when high
  output wire [15:0] mem_addr_o,      // Memory word address
  output wire [15:0] mem_wdata_o,     // Memory write data
  input  wire [15:0] mem_rdata_i,     // Memory read data, valid with ready
  input  wire        mem_ready_i      // Memory access complete
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [9:0] S_IDLE = 10'h001, S_RDD0 = 10'h002, S_RDD1 = 10'h004, S_WRD0 = 10'h008,
                   S_WRD1 = 10'h010, S_RDF0 = 10'h020, S_RDF1 = 10'h040, S_WRF0 = 10'h080,
                   S_WRF1 = 10'h100, S_FIN  = 10'h200;

  function [2:0] gr_slot;             // Index code or offset word to array slot
    input [2:0] code;
    gr_slot = code - `BFAU_GR_BASE;
  endfunction

  reg  [9:0]  state_r, state_nxt;
  reg  [15:0] gr_r [0:5];
  reg  [8:0]  ctrl_r;
  reg  [15:0] daddr_r, d0_r, d1_r, w0_r, w1_r;
  reg         ovf_r, carry_r, post_r;
  reg  [15:0] maddr_r, mwdata_r, maddr_nxt, mwdata_nxt;
  reg         mwe_r, mwe_nxt;
  reg  [7:0]  awaddr_r, araddr_r;
  reg  [31:0] wdata_r, rdata_r;
  reg  [3:0]  wstrb_r;
  reg         aw_have_r, w_have_r, bvalid_r, rvalid_r;
  reg  [1:0]  bresp_r, rresp_r;
  integer     i;

  // ----------------------------------------------------------------
  // Descriptor and field arithmetic
  // ----------------------------------------------------------------
  wire        busy    = ~state_r[0];
  wire        rdy     = mem_ready_i;
  wire [2:0]  op      = ctrl_r[`BFAU_OP_HI:`BFAU_OP_LO];
  wire [2:0]  idx     = ctrl_r[`BFAU_IDX_HI:`BFAU_IDX_LO];
  wire [2:0]  selfc   = ctrl_r[`BFAU_SELF_HI:`BFAU_SELF_LO];
  wire        inc     = (selfc == `BFAU_SELF_INC);
  wire        dec     = (selfc == `BFAU_SELF_DEC);
  wire        is_cmp  = (op == `BFAU_OP_CMP_U) | (op == `BFAU_OP_CMP_S);
  wire        is_st   = (op == `BFAU_OP_STORE) | (op == `BFAU_OP_ZERO) | (op == `BFAU_OP_ONES);
  // Live copies: a word is usable in the same cycle it arrives
  wire [15:0] d1_v    = (state_r[2] & rdy) ? mem_rdata_i : d1_r;
  wire [15:0] w0_v    = (state_r[5] & rdy) ? mem_rdata_i : w0_r;
  wire [15:0] w1_v    = (state_r[6] & rdy) ? mem_rdata_i : w1_r;
  wire [19:0] start   = {d0_r, d1_v[`BFAU_POS_HI:`BFAU_POS_LO]};
  wire [3:0]  flen    = d1_v[`BFAU_LEN_HI:`BFAU_LEN_LO];
  wire [7:0]  cnt     = d1_v[`BFAU_CNT_HI:`BFAU_CNT_LO];
  wire [4:0]  n       = {1'b0, flen} + 5'h01;                     // Field size 1..16
  // Increment and decrement both work from the original descriptor
  wire [19:0] st_new  = dec ? start - {15'h0000, n} : start + {15'h0000, n};
  wire [7:0]  cnt_new = dec ? cnt - `BFAU_CNT_ONE : cnt + `BFAU_CNT_ONE;
  wire [15:0] nd0     = st_new[19:4];
  wire [15:0] nd1     = {st_new[3:0], flen, cnt_new};
  // Decrement never moves the current field; increment does
  wire [19:0] base    = inc ? st_new : start;
  wire [15:0] xval    = (idx > `BFAU_IDX_NONE) ? gr_r[gr_slot(idx)] : 16'h0000;
  wire [15:0] eword   = base[19:4] + xval;
  wire [3:0]  pos     = base[3:0];
  wire        span    = ({1'b0, pos} + n) > `BFAU_WORD_MAX;
  // Field extraction from a two-word window
  wire [4:0]  rsh     = `BFAU_WORD_MAX - n;
  wire [15:0] fmask   = 16'hFFFF >> rsh;
  wire [31:0] win     = {w0_r, w1_r} << pos;
  wire [15:0] fld     = win[31:16] >> rsh;
  wire        lbit    = win[31];
  wire [15:0] fld_s   = fld | (lbit ? ~fmask : 16'h0000);
  // Masked merge for stores
  wire [5:0]  msh     = `BFAU_DWORD_W - {2'b00, pos} - {1'b0, n};
  wire [15:0] acc     = gr_r[5];
  wire [15:0] sval    = (op == `BFAU_OP_ONES) ? 16'hFFFF :
                        (op == `BFAU_OP_ZERO) ? 16'h0000 : acc;
  wire [31:0] mk32    = {16'h0000, fmask} << msh;
  wire [31:0] dv32    = {16'h0000, sval & fmask} << msh;
  wire [31:0] merged  = ({w0_v, w1_v} & ~mk32) | (dv32 & mk32);
  // Compare as a subtraction A minus comparand
  wire [15:0] cmpd    = (op == `BFAU_OP_CMP_S) ? fld_s : fld;
  wire [16:0] diff    = {1'b0, acc} - {1'b0, cmpd};
  wire        c_carry = ~diff[16];
  wire        c_ovf   = (acc[15] ^ cmpd[15]) & (acc[15] ^ diff[15]);
  wire        cnt_ovf = (inc & (cnt_new == `BFAU_CNT_ZERO)) |
                        (dec & (cnt_new == `BFAU_CNT_ONES));

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  wire        do_wr   = aw_have_r & w_have_r & ~bvalid_r;
  wire        do_rd   = s_axi_arvalid & ~rvalid_r;
  wire        start_w = do_wr & (awaddr_r == `BFAU_OFF_CTRL) & ~busy;
  wire        gr_hit  = (awaddr_r >= `BFAU_OFF_GR_LO) & (awaddr_r <= `BFAU_OFF_GR_HI) &
                        (awaddr_r[1:0] == 2'b00);

  assign s_axi_awready = ~aw_have_r & ~bvalid_r;
  assign s_axi_wready  = ~w_have_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign mem_req_o     = busy & ~state_r[9];
  assign mem_we_o      = mwe_r;
  assign mem_addr_o    = maddr_r;
  assign mem_wdata_o   = mwdata_r;

  // Write channel capture, either order, one write outstanding
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `BFAU_RESP_OKAY;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        // Writes refused while busy still answer, but with an error
        if ((awaddr_r == `BFAU_OFF_CTRL || awaddr_r == `BFAU_OFF_DADDR || gr_hit) && !busy)
          bresp_r <= `BFAU_RESP_OKAY;
        else
          bresp_r <= `BFAU_RESP_SLV;
      end else if (bvalid_r & s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read channel, one-cycle answer
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= `BFAU_RESP_OKAY;
    end else if (do_rd) begin
      rvalid_r <= 1'b1;
      rresp_r  <= `BFAU_RESP_OKAY;
      rdata_r  <= 32'h00000000;
      if (s_axi_araddr == `BFAU_OFF_CTRL)
        rdata_r <= {23'h000000, ctrl_r};
      else if (s_axi_araddr == `BFAU_OFF_DADDR)
        rdata_r <= {16'h0000, daddr_r};
      else if (s_axi_araddr >= `BFAU_OFF_GR_LO && s_axi_araddr <= `BFAU_OFF_GR_HI &&
               s_axi_araddr[1:0] == 2'b00)
        rdata_r <= {16'h0000, gr_r[gr_slot(s_axi_araddr[4:2])]};
      else if (s_axi_araddr == `BFAU_OFF_STAT)
        rdata_r <= {29'h00000000, carry_r, ovf_r, busy};
      else
        rresp_r <= `BFAU_RESP_SLV;
    end else if (rvalid_r & s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state: descriptor read, optional pre-increment, field, optional post-decrement
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: if (start_w) state_nxt = S_RDD0;
      S_RDD0: if (rdy) state_nxt = S_RDD1;
      S_RDD1: if (rdy) state_nxt = inc ? S_WRD0 : S_RDF0;
      S_WRD0: if (rdy) state_nxt = S_WRD1;
      S_WRD1: if (rdy) state_nxt = post_r ? S_FIN : S_RDF0;
      S_RDF0: if (rdy) state_nxt = span ? S_RDF1 : is_st ? S_WRF0 : dec ? S_WRD0 : S_FIN;
      S_RDF1: if (rdy) state_nxt = is_st ? S_WRF0 : dec ? S_WRD0 : S_FIN;
      S_WRF0: if (rdy) state_nxt = span ? S_WRF1 : dec ? S_WRD0 : S_FIN;
      S_WRF1: if (rdy) state_nxt = dec ? S_WRD0 : S_FIN;
      S_FIN:  state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // Memory address and data for the state about to be entered
  always @* begin
    maddr_nxt  = 16'h0000;
    mwdata_nxt = 16'h0000;
    mwe_nxt    = 1'b0;
    case (state_nxt)
      S_RDD0: maddr_nxt = daddr_r;
      S_RDD1: maddr_nxt = daddr_r + 16'h0001;
      S_WRD0: begin
        maddr_nxt  = daddr_r;
        mwdata_nxt = nd0;
        mwe_nxt    = 1'b1;
      end
      S_WRD1: begin
        maddr_nxt  = daddr_r + 16'h0001;
        mwdata_nxt = nd1;
        mwe_nxt    = 1'b1;
      end
      S_RDF0: maddr_nxt = eword;
      S_RDF1: maddr_nxt = eword + 16'h0001;
      S_WRF0: begin
        maddr_nxt  = eword;
        mwdata_nxt = merged[31:16];
        mwe_nxt    = 1'b1;
      end
      S_WRF1: begin
        maddr_nxt  = eword + 16'h0001;
        mwdata_nxt = merged[15:0];
        mwe_nxt    = 1'b1;
      end
      default: maddr_nxt = 16'h0000;
    endcase
  end

  // Sequencer registers and captured memory words
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r  <= S_IDLE;
      maddr_r  <= 16'h0000;
      mwdata_r <= 16'h0000;
      mwe_r    <= 1'b0;
      post_r   <= 1'b0;
      d0_r     <= 16'h0000;
      d1_r     <= 16'h0000;
      w0_r     <= 16'h0000;
      w1_r     <= 16'h0000;
    end else begin
      state_r  <= state_nxt;
      maddr_r  <= maddr_nxt;
      mwdata_r <= mwdata_nxt;
      mwe_r    <= mwe_nxt;
      if (state_r[0]) begin
        post_r <= 1'b0;
        w1_r   <= 16'h0000;                                       // Unused half of a short window
      end
      // A descriptor write pass entered from a field state is the post-decrement one
      if ((state_r[5] | state_r[6] | state_r[7] | state_r[8]) & (state_nxt == S_WRD0))
        post_r <= 1'b1;
      if (state_r[1] & rdy) d0_r <= mem_rdata_i;
      if (state_r[2] & rdy) d1_r <= mem_rdata_i;
      if (state_r[5] & rdy) w0_r <= mem_rdata_i;
      if (state_r[6] & rdy) w1_r <= mem_rdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Software registers and results
  // ----------------------------------------------------------------
  // Software writes only while idle; A and flags updated at the finish step
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r  <= 9'h000;
      daddr_r <= 16'h0000;
      ovf_r   <= 1'b0;
      carry_r <= 1'b0;
      for (i = 0; i < 6; i = i + 1)
        gr_r[i] <= 16'h0000;
    end else if (state_r[9]) begin
      case (op)
        `BFAU_OP_LOAD_U: gr_r[5] <= fld;
        `BFAU_OP_LOAD_S: gr_r[5] <= fld_s;
        `BFAU_OP_SENSE:  carry_r <= lbit;
        default:         gr_r[5] <= gr_r[5];                      // Stores keep A
      endcase
      if (is_cmp) begin
        ovf_r   <= c_ovf;
        carry_r <= c_carry;
      end else begin
        ovf_r <= cnt_ovf;
      end
    end else if (do_wr && !busy) begin
      if (awaddr_r == `BFAU_OFF_CTRL && wstrb_r[0])
        ctrl_r <= wdata_r[8:0];
      else if (awaddr_r == `BFAU_OFF_DADDR) begin
        if (wstrb_r[0]) daddr_r[7:0]  <= wdata_r[7:0];
        if (wstrb_r[1]) daddr_r[15:8] <= wdata_r[15:8];
      end else if (gr_hit) begin
        if (wstrb_r[0]) gr_r[gr_slot(awaddr_r[4:2])][7:0]  <= wdata_r[7:0];
        if (wstrb_r[1]) gr_r[gr_slot(awaddr_r[4:2])][15:8] <= wdata_r[15:8];
      end
    end
  end
endmodule // bfau_core

// ---- bfau_map.vh ----
// Address map, field layout and encodings of the bit-field access unit
`ifndef BFAU_MAP_VH
`define BFAU_MAP_VH
// ----------------------------------------------------------------
// Register byte offsets (AXI4-Lite)
// ----------------------------------------------------------------
`define BFAU_OFF_CTRL   8'h00
`define BFAU_OFF_DADDR  8'h04
`define BFAU_OFF_GR_LO  8'h08
`define BFAU_OFF_GR_HI  8'h1C
`define BFAU_OFF_STAT   8'h20
`define BFAU_GR_BASE    3'h2
`define BFAU_RESP_OKAY  2'h0
`define BFAU_RESP_SLV   2'h2
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define BFAU_OP_HI      2
`define BFAU_OP_LO      0
`define BFAU_IDX_HI     5
`define BFAU_IDX_LO     3
`define BFAU_SELF_HI    8
`define BFAU_SELF_LO    6
// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define BFAU_ST_BUSY    0
`define BFAU_ST_OVF     1
`define BFAU_ST_CARRY   2
// ----------------------------------------------------------------
// Field operation codes
// ----------------------------------------------------------------
`define BFAU_OP_LOAD_U  3'h0
`define BFAU_OP_LOAD_S  3'h1
`define BFAU_OP_STORE   3'h2
`define BFAU_OP_ZERO    3'h3
`define BFAU_OP_ONES    3'h4
`define BFAU_OP_CMP_U   3'h5
`define BFAU_OP_CMP_S   3'h6
`define BFAU_OP_SENSE   3'h7
// ----------------------------------------------------------------
// Self-index and register-index codes
// ----------------------------------------------------------------
`define BFAU_SELF_NONE  3'h0
`define BFAU_SELF_INC   3'h1
`define BFAU_SELF_DEC   3'h7
`define BFAU_IDX_NONE   3'h1
// ----------------------------------------------------------------
// Descriptor second-word layout
// ----------------------------------------------------------------
`define BFAU_POS_HI     15
`define BFAU_POS_LO     12
`define BFAU_LEN_HI     11
`define BFAU_LEN_LO     8
`define BFAU_CNT_HI     7
`define BFAU_CNT_LO     0
`define BFAU_CNT_ONE    8'h01
`define BFAU_CNT_ZERO   8'h00
`define BFAU_CNT_ONES   8'hFF
`define BFAU_WORD_MAX   5'h10
`define BFAU_DWORD_W    6'h20
`endif

// ---- bfau_mem_model.sv ----
// Behavioural word memory on the far side of the field unit
`timescale 1ns/100ps
module bfau_mem_model (
  input  wire        clk_i,    // Processor clock
  input  wire        resetn_i, // Async reset, active low
  input  wire [1:0]  lat_i,    // Wait cycles per access
  input  wire        req_i,    // Access request
  input  wire        we_i,     // Write when high
  input  wire [15:0] addr_i,   // Word address
  input  wire [15:0] wdata_i,  // Write data
  output reg  [15:0] rdata_o,  // Read data, valid with ready
  output reg         ready_o   // One-cycle completion
);
  reg [15:0] mem [0:63];
  reg [1:0]  wait_r;
  reg [15:0] junk_r;
  // Ready pulses once per request; no pipelining, so never offered early
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ready_o <= 1'b0;
      wait_r <= 2'h0;
      junk_r <= 16'h5A5A;
    end else begin
      junk_r <= ~junk_r;
      ready_o <= 1'b0;
      if (req_i && !ready_o && wait_r == lat_i) begin
        ready_o <= 1'b1;
        wait_r <= 2'h0;
      end else if (req_i && !ready_o)
        wait_r <= wait_r + 2'h1;
      if (req_i && ready_o && we_i)
        mem[addr_i[5:0]] <= wdata_i;
    end
  end
  // Outside the ready cycle the bus shows a toggling pattern, not stale data
  always @* begin
    rdata_o = ready_o ? mem[addr_i[5:0]] : junk_r;
  end
endmodule // bfau_mem_model

// ---- bfau_chk.sv ----
// Concurrent checks on the field unit's bus and memory ports
`timescale 1ns/100ps
module bfau_chk (
  input wire        clk_i,         // Clock
  input wire        resetn_i,      // Reset, active low
  input wire        s_axi_awready, // AW ready
  input wire        s_axi_wready,  // W ready
  input wire        s_axi_bvalid,  // B valid
  input wire        s_axi_bready,  // B ready
  input wire [1:0]  s_axi_bresp,   // B response
  input wire        s_axi_arready, // AR ready
  input wire        s_axi_rvalid,  // R valid
  input wire        s_axi_rready,  // R ready
  input wire        mem_req_o,     // Memory request
  input wire        mem_we_o,      // Memory write
  input wire [15:0] mem_addr_o,    // Memory address
  input wire [15:0] mem_wdata_o,   // Memory write data
  input wire [15:0] mem_rdata_i,   // Memory read data
  input wire        mem_ready_i    // Memory ready
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  reg [2:0]  acc_n_r;
  reg [15:0] base_r;
  reg [15:0] d1_r;
  // Accesses of one operation; the first two carry the descriptor
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_n_r <= 3'h0;
      base_r <= 16'h0;
      d1_r <= 16'h0;
    end else if (!mem_req_o)
      acc_n_r <= 3'h0;
    else if (mem_ready_i) begin
      acc_n_r <= (acc_n_r == 3'h7) ? acc_n_r : acc_n_r + 3'h1;
      if (acc_n_r == 3'h0)
        base_r <= mem_addr_o;
      if (acc_n_r == 3'h1)
        d1_r <= mem_rdata_i;
    end
  end
  a_req_hold: assert property (mem_req_o && !mem_ready_i |=> mem_req_o && $stable(mem_addr_o)
    && $stable(mem_we_o) && $stable(mem_wdata_o)) else $error("memory request moved before ready");
  a_first_read: assert property ($rose(mem_req_o) |-> !mem_we_o) else $error("operation began with a write");
  a_desc_pair: assert property (mem_req_o && acc_n_r == 3'h1 |-> !mem_we_o && mem_addr_o == base_r + 16'h1)
    else $error("second descriptor word not read next");
  a_len_keep: assert property (mem_req_o && mem_we_o && acc_n_r >= 3'h2 && mem_addr_o == base_r + 16'h1
    |-> mem_wdata_o[11:8] == d1_r[11:8] && (mem_wdata_o[7:0] == d1_r[7:0] + 8'h1
    || mem_wdata_o[7:0] == d1_r[7:0] - 8'h1)) else $error("descriptor write-back corrupt");
  a_no_early_wr: assert property (mem_req_o && acc_n_r < 3'h2 |-> !mem_we_o)
    else $error("write before descriptor read");
  a_op_bound: assert property ($rose(mem_req_o) |-> ##[1:120] !mem_req_o) else $error("operation never ended");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid held");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid held");
  a_bus_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready during bvalid");
  a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during rvalid");
  // Main scenarios reached
  cover property ($rose(mem_req_o));
  cover property (mem_req_o && mem_we_o && mem_ready_i);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // bfau_chk
bind bfau_core bfau_chk u_chk (.clk_i, .resetn_i, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .mem_req_o, .mem_we_o, .mem_addr_o,
  .mem_wdata_o, .mem_rdata_i, .mem_ready_i);

// ---- bit_field_access_unit_tb.sv ----
// Self-checking bench for the bit-field access unit
`timescale 1ns/100ps
`include "bfau_map.vh"
module bit_field_access_unit_tb;
  reg         clk_i, resetn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, rd, st;
  reg  [3:0]  s_axi_wstrb;
  reg  [1:0]  lat, rsp;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        mem_req_o, mem_we_o, mem_ready_i;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
  integer     n_fail, compares;
  bfau_core DUT (.clk_i, .resetn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req_o, .mem_we_o,
    .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ready_i);
  bfau_mem_model u_mem (.clk_i, .resetn_i, .lat_i(lat), .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i), .ready_o(mem_ready_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // Bus tasks and judging
  // ----------------------------------------------------------------
  task summarize;
    begin
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task automatic chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task hang;
    begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: wait limit ran out", $time);
      summarize;
    end
  endtask
  // Ready is sampled at the falling edge, where it already holds its rising-edge value
  task automatic axi_wr(input [7:0] a, input [31:0] d, output [1:0] r);
    integer k;
    reg aw_h, w_h, b_h;
    begin
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b_h = 1'b0;
      for (k = 0; k < 100 && !b_h; k = k + 1) begin
        @(negedge clk_i);
        aw_h = s_axi_awready;
        w_h = s_axi_wready;
        b_h = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge clk_i);
        if (aw_h)
          s_axi_awvalid <= 1'b0;
        if (w_h)
          s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      if (!b_h)
        hang;
    end
  endtask
  task automatic axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
    integer k;
    reg ar_h, r_h;
    begin
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r_h = 1'b0;
      for (k = 0; k < 100 && !r_h; k = k + 1) begin
        @(negedge clk_i);
        ar_h = s_axi_arready;
        r_h = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk_i);
        if (ar_h)
          s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      if (!r_h)
        hang;
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    begin
      axi_wr(a, d, rsp);
      chk(rsp, `BFAU_RESP_OKAY);
    end
  endtask
  task automatic expect_rd(input [7:0] a, input [31:0] e);
    begin
      axi_rd(a, rd, rsp);
      chk(rd, e);
    end
  endtask
  task automatic wait_idle;
    integer k;
    begin
      st = 32'h1;
      for (k = 0; k < 60 && st[`BFAU_ST_BUSY] !== 1'b0; k = k + 1)
        axi_rd(`BFAU_OFF_STAT, st, rsp);
      if (st[`BFAU_ST_BUSY] !== 1'b0)
        hang;
    end
  endtask
  // One self code per operation; increment and decrement never together
  task automatic run_op(input [2:0] op, input [2:0] idx, input [2:0] slf);
    begin
      wr(`BFAU_OFF_CTRL, {23'h0, slf, idx, op});
      wait_idle;
    end
  endtask
  task automatic prep(input [15:0] d1, input [15:0] w0, input [15:0] w1);
    begin
      u_mem.mem[16] = 16'h0020;
      u_mem.mem[17] = d1;
      u_mem.mem[32] = w0;
      u_mem.mem[33] = w1;
    end
  endtask
  // Field merge in the big-endian bit order of the two-word pair
  function automatic [31:0] fput(input [31:0] old, input [15:0] v, input [3:0] pos, input [4:0] n);
    reg [31:0] m;
    begin
      m = ((32'h1 << n) - 32'h1) << (32 - pos - n);
      fput = (old & ~m) | (({16'h0, v} << (32 - pos - n)) & m);
    end
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task s_reset;
    begin
      expect_rd(`BFAU_OFF_GR_HI, 32'h0);
      expect_rd(`BFAU_OFF_STAT, 32'h0);
      expect_rd(8'h24, 32'h0);
      chk(rsp, `BFAU_RESP_SLV);
      axi_wr(`BFAU_OFF_STAT, 32'h7, rsp);
      chk(rsp, `BFAU_RESP_SLV);
      wr(`BFAU_OFF_DADDR, 32'h10);
      expect_rd(`BFAU_OFF_DADDR, 32'h10);
    end
  endtask
  // Straddling 8-bit field 0xAB at word 0x20, bit 12
  task s_load;
    begin
      prep(16'hC705, 16'h000A, 16'hB000);
      run_op(`BFAU_OP_LOAD_U, `BFAU_IDX_NONE, `BFAU_SELF_NONE);
      expect_rd(`BFAU_OFF_GR_HI, 32'h00AB);
      run_op(`BFAU_OP_LOAD_S, `BFAU_IDX_NONE, `BFAU_SELF_NONE);
      expect_rd(`BFAU_OFF_GR_HI, 32'hFFAB);
      chk(u_mem.mem[17], 16'hC705);
    end
  endtask
  task s_store;
    integer i;
    reg [2:0]  op;
    reg [31:0] e;
    begin
      lat <= 2'h1;
      wr(`BFAU_OFF_GR_LO, 32'h2);
      wr(`BFAU_OFF_GR_HI, 32'h1234);
      for (i = 0; i < 3; i = i + 1) begin
        op = `BFAU_OP_STORE + i[2:0];
        prep(16'hC705, 16'h0, 16'h0);
        u_mem.mem[34] = 16'hA5A5;
        u_mem.mem[35] = 16'h5A5A;
        run_op(op, 3'h2, `BFAU_SELF_NONE);
        e = fput(32'hA5A55A5A, (i == 0) ? 16'h1234 : (i == 1) ? 16'h0 : 16'hFFFF, 4'hC, 5'h8);
        chk(u_mem.mem[34], e[31:16]);
        chk(u_mem.mem[35], e[15:0]);
        chk(u_mem.mem[17], 16'hC705);
        expect_rd(`BFAU_OFF_GR_HI, 32'h1234);
      end
    end
  endtask
  task s_inc;
    begin
      lat <= 2'h0;
      prep(16'hC7FF, 16'hFFFF, 16'h0AB0);
      run_op(`BFAU_OP_LOAD_U, `BFAU_IDX_NONE, `BFAU_SELF_INC);
      expect_rd(`BFAU_OFF_GR_HI, 32'h00AB);
      chk(u_mem.mem[16], 16'h0021);
      chk(u_mem.mem[17], 16'h4700);
      chk(st, 32'h2);
    end
  endtask
  // Index T=1 from the original address; decrement lands last
  task s_dec;
    begin
      wr(`BFAU_OFF_GR_LO + 8'h4, 32'h1);
      wr(`BFAU_OFF_GR_HI, 32'h0100);
      prep(16'h4300, 16'h0000, 16'h0800);
      run_op(`BFAU_OP_SENSE, 3'h3, `BFAU_SELF_DEC);
      chk(st, 32'h6);
      chk(u_mem.mem[16], 16'h0020);
      chk(u_mem.mem[17], 16'h03FF);
      chk(u_mem.mem[33], 16'h0800);
      expect_rd(`BFAU_OFF_GR_HI, 32'h0100);
    end
  endtask
  task s_cmp;
    begin
      prep(16'hC700, 16'h000A, 16'hB000);
      run_op(`BFAU_OP_CMP_U, `BFAU_IDX_NONE, `BFAU_SELF_DEC);
      chk(st, 32'h4);
      chk(u_mem.mem[17], 16'h47FF);
      prep(16'hC700, 16'h000A, 16'hB000);
      run_op(`BFAU_OP_CMP_S, `BFAU_IDX_NONE, `BFAU_SELF_NONE);
      chk(st, 32'h0);
      expect_rd(`BFAU_OFF_GR_HI, 32'h0100);
    end
  endtask
  // Slow memory; a write during the operation must be refused
  task s_busy;
    begin
      lat <= 2'h3;
      prep(16'hC705, 16'h000A, 16'hB000);
      wr(`BFAU_OFF_CTRL, {23'h0, `BFAU_SELF_NONE, `BFAU_IDX_NONE, `BFAU_OP_LOAD_U});
      axi_wr(`BFAU_OFF_GR_HI, 32'h7777, rsp);
      chk(rsp, `BFAU_RESP_SLV);
      wait_idle;
      expect_rd(`BFAU_OFF_GR_HI, 32'h00AB);
    end
  endtask
  initial begin
    resetn_i = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    lat = 2'h0;
    n_fail = 0;
    compares = 0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    s_reset;
    s_load;
    s_store;
    s_inc;
    s_dec;
    s_cmp;
    s_busy;
    summarize;
  end
endmodule // bit_field_access_unit_tb
